//--- dv/low_voltage_idle_gating_tb.sv
// Purpose: self-checking bench for the low-voltage sub-idle gating block
// Assumes: register map, entry and wake behaviour as described for the block's bus
// Notes: assertions live beside the design logic; this bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module low_voltage_idle_gating_tb;
    // ==========================================
    // signals and instance
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic low_voltage_detector_en, subclk_osc_en, int_osc_en, pll_en, main_clk_en, cpu_clk_en, dma_en;
    logic timer_p_units_en, timer_q_unit_en, i2c_units_en, crc_en, clocked_serial_units_en;
    logic async_serial_units_en, adc_en, dac_en, realtime_output_update_en, interval_timer_m_en, wdt2_en;
    logic watch_rtc_en, intc_run_en, intc_wake_en, key_interrupt_unit_en, port_hold, cpu_reg_hold, lv_subclk_mode;
    int err_total = 0;
    int n_checks = 0;

    low_voltage_idle_gating dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .wake_req,
        .low_voltage_detector_en, .subclk_osc_en, .int_osc_en, .pll_en, .main_clk_en, .cpu_clk_en, .dma_en,
        .timer_p_units_en, .timer_q_unit_en, .i2c_units_en, .crc_en, .clocked_serial_units_en,
        .async_serial_units_en, .adc_en, .dac_en, .realtime_output_update_en, .interval_timer_m_en, .wdt2_en,
        .watch_rtc_en, .intc_run_en, .intc_wake_en, .key_interrupt_unit_en, .port_hold, .cpu_reg_hold,
        .lv_subclk_mode);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ==========================================
    // helpers
    function automatic logic [31:0] ctrl_word(input logic [1:0] pms, input logic stp, pll, mrun, lv);
        return (32'(pms) << lv_idle_pkg::PMS_LSB) | (32'(stp) << lv_idle_pkg::STOP_BIT)
            | (32'(pll) << lv_idle_pkg::PLL_RUN_BIT) | (32'(mrun) << lv_idle_pkg::MAIN_RUN_BIT)
            | (32'(lv) << lv_idle_pkg::LV_MODE_BIT);
    endfunction

    function automatic logic [31:0] sel_word(input logic [1:0] tmm, wdt, input logic ws, adc, dac);
        return (32'(tmm) << lv_idle_pkg::TMM_SEL_LSB) | (32'(wdt) << lv_idle_pkg::WDT_SEL_LSB)
            | (32'(ws) << lv_idle_pkg::WATCH_SUB_BIT) | (32'(adc) << lv_idle_pkg::ADC_RUN_BIT)
            | (32'(dac) << lv_idle_pkg::DAC_RUN_BIT);
    endfunction

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // bus master tasks
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no limit here: only the bench watchdog ends a stuck wait
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        chk32(32'(r), 32'(lv_idle_pkg::RESP_OKAY), "write resp");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk32(32'(r), 32'(lv_idle_pkg::RESP_OKAY), "read resp");
        chk32(d, exp, "read data");
    endtask

    task automatic chk_gates(input logic idle, itm, wdt, rtc, adc, dac);
        #1;
        chk32(32'({cpu_clk_en, dma_en, timer_p_units_en, timer_q_unit_en, i2c_units_en, crc_en}),
            32'({6{~idle}}), "core gates");
        chk32(32'({clocked_serial_units_en, async_serial_units_en}), 32'({2{~idle}}), "serial");
        chk32(32'({realtime_output_update_en, intc_run_en}), 32'({2{~idle}}), "rto intc");
        chk32(32'({port_hold, cpu_reg_hold}), 32'({2{idle}}), "hold");
        chk32(32'({low_voltage_detector_en, subclk_osc_en, int_osc_en, intc_wake_en, key_interrupt_unit_en}),
            32'h1F, "always on");
        chk32(32'({interval_timer_m_en, wdt2_en}), 32'({itm, wdt}), "timer m wdt");
        chk32(32'(watch_rtc_en), 32'(rtc), "watch rtc");
        chk32(32'({adc_en, dac_en}), 32'({adc, dac}), "converters");
        chk32(32'(pll_en), 32'h0, "pll");
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        rd_chk(lv_idle_pkg::CTRL_OFS, ctrl_word(lv_idle_pkg::PMS_RESET, 1'b0, lv_idle_pkg::PLL_RUN_RESET,
            lv_idle_pkg::MAIN_RUN_RESET, lv_idle_pkg::LV_MODE_RESET));
        rd_chk(lv_idle_pkg::CLKSEL_OFS, sel_word(lv_idle_pkg::SEL_RESET, lv_idle_pkg::SEL_RESET, 1'b0, 1'b0, 1'b0));
        rd_chk(lv_idle_pkg::STATUS_OFS, 32'h0);
        chk_gates(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        chk32(32'({main_clk_en, lv_subclk_mode}), 32'h2, "reset clocks");
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0] r;
        axi_write(8'h0C, 32'hFF, r);
        chk32(32'(r), 32'(lv_idle_pkg::RESP_SLVERR), "unmapped write");
        axi_read(8'h0C, d, r);
        chk32(32'(r), 32'(lv_idle_pkg::RESP_SLVERR), "unmapped read");
        chk32(d, 32'h0, "unmapped data");
    endtask

    // entry attempts that must be refused
    task automatic t_refuse;
        logic [31:0] bad [5];
        bad[0] = ctrl_word(2'h1, 1'b1, 1'b0, 1'b0, 1'b1);
        bad[1] = ctrl_word(2'h3, 1'b1, 1'b0, 1'b0, 1'b1);
        bad[2] = ctrl_word(lv_idle_pkg::PMS_SUB_IDLE_A, 1'b1, 1'b0, 1'b1, 1'b1);
        bad[3] = ctrl_word(lv_idle_pkg::PMS_SUB_IDLE_B, 1'b1, 1'b0, 1'b0, 1'b0);
        bad[4] = ctrl_word(lv_idle_pkg::PMS_SUB_IDLE_B, 1'b1, 1'b1, 1'b0, 1'b1);
        foreach (bad[i]) begin
            wr_ok(lv_idle_pkg::CTRL_OFS, bad[i]);
            #1;
            chk32(32'(port_hold), 32'h0, "refused entry held");
            rd_chk(lv_idle_pkg::STATUS_OFS, 32'h1 << lv_idle_pkg::REFUSED_BIT);
            wr_ok(lv_idle_pkg::STATUS_OFS, 32'h1 << lv_idle_pkg::REFUSED_BIT);
            rd_chk(lv_idle_pkg::STATUS_OFS, 32'h0);
        end
        chk32(32'({pll_en, main_clk_en}), 32'h2, "pll follows software");
        wr_ok(lv_idle_pkg::CTRL_OFS, ctrl_word(2'h0, 1'b0, 1'b0, 1'b1, 1'b0));
        chk32(32'({pll_en, main_clk_en}), 32'h1, "main clock back");
    endtask

    task automatic t_enter_wake(input logic [1:0] pms, input logic [31:0] sel, input logic itm, wdt, rtc);
        logic adc, dac;
        adc = sel[lv_idle_pkg::ADC_RUN_BIT];
        dac = sel[lv_idle_pkg::DAC_RUN_BIT];
        wr_ok(lv_idle_pkg::CLKSEL_OFS, sel);
        wr_ok(lv_idle_pkg::CTRL_OFS, ctrl_word(pms, 1'b0, 1'b0, 1'b0, 1'b1));
        chk_gates(1'b0, 1'b1, 1'b1, 1'b1, adc, dac);
        chk32(32'(main_clk_en), 32'h0, "main clock stopped");
        wr_ok(lv_idle_pkg::CTRL_OFS, ctrl_word(pms, 1'b1, 1'b0, 1'b0, 1'b1));
        chk_gates(1'b1, itm, wdt, rtc, 1'b0, 1'b0);
        // writes while idle must not restart the pll or main clock
        wr_ok(lv_idle_pkg::CTRL_OFS, ctrl_word(pms, 1'b0, 1'b1, 1'b1, 1'b1));
        rd_chk(lv_idle_pkg::CTRL_OFS, ctrl_word(pms, 1'b0, 1'b0, 1'b0, 1'b1));
        rd_chk(lv_idle_pkg::STATUS_OFS, 32'h1 << lv_idle_pkg::IDLE_BIT);
        chk_gates(1'b1, itm, wdt, rtc, 1'b0, 1'b0);
        @(posedge aclk);
        wake_req <= 1'b1;
        repeat (2) @(posedge aclk);
        wake_req <= 1'b0;
        chk_gates(1'b0, 1'b1, 1'b1, 1'b1, adc, dac);
        chk32(32'({lv_subclk_mode, pll_en, main_clk_en}), 32'h4, "wake mode");
        rd_chk(lv_idle_pkg::STATUS_OFS, 32'h1 << lv_idle_pkg::WOKE_BIT);
        wr_ok(lv_idle_pkg::STATUS_OFS, 32'h1 << lv_idle_pkg::WOKE_BIT);
        rd_chk(lv_idle_pkg::STATUS_OFS, 32'h0);
    endtask

    // a wake request already pending blocks entry
    task automatic t_pending;
        @(posedge aclk);
        wake_req <= 1'b1;
        wr_ok(lv_idle_pkg::CTRL_OFS, ctrl_word(lv_idle_pkg::PMS_SUB_IDLE_A, 1'b1, 1'b0, 1'b0, 1'b1));
        #1;
        chk32(32'({port_hold, cpu_clk_en}), 32'h1, "pending wake entry");
        rd_chk(lv_idle_pkg::STATUS_OFS, 32'h1 << lv_idle_pkg::REFUSED_BIT);
        @(posedge aclk);
        wake_req <= 1'b0;
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, wake_req} = 6'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_unmapped;
        t_refuse;
        t_enter_wake(lv_idle_pkg::PMS_SUB_IDLE_A, sel_word(2'h1, 2'h2, 1'b1, 1'b1, 1'b1), 1'b1, 1'b1, 1'b1);
        t_enter_wake(lv_idle_pkg::PMS_SUB_IDLE_B, sel_word(2'h0, 2'h3, 1'b0, 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
        t_enter_wake(lv_idle_pkg::PMS_SUB_IDLE_A, sel_word(2'h2, 2'h1, 1'b0, 1'b1, 1'b0), 1'b1, 1'b1, 1'b0);
        t_pending;
        tally_and_finish;
    end

    // the tests need well under 2000 cycles
    initial begin
        #100000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule
`default_nettype wire

//--- rtl/low_voltage_idle_gating.sv
// Purpose: gates on-chip units while the chip sits in low-voltage sub-idle standby
// Assumes: one clock, synchronous active-low reset, AXI4-Lite register access
// Notes: gate outputs are decoded from flip-flops only
// Functional notes
// - Low-voltage sub-idle entered only with main clock stopped; no main-clock logic runs.
// - Interrupt controller halts in standby but still accepts wake-up requests.
// - Interval timer M and watchdog 2 run only on oscillator/8 or subclock.
// - Watch timer and real-time clock run only when subclock is selected.
// - Analog-to-digital stops; digital-to-analog must already be stopped by software (entry does not check it; dac_en is gated off in standby).
// - Real-time output stops updating and holds its last pin values.
// - Key-interrupt detection stays fully operable during standby.
// - Port pins and processor registers are held unchanged throughout standby.
// - Interrupt release resumes in low-voltage subclock operation mode.
// - On release the PLL stays stopped, never restarted automatically.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module low_voltage_idle_gating (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // wake-up request from interrupt sources
    input wire logic wake_req,
    // always-on units, then pll and main clock enables (stopped in standby)
    output logic low_voltage_detector_en,
    output logic subclk_osc_en,
    output logic int_osc_en,
    output logic pll_en,
    output logic main_clk_en,
    // units stopped in standby
    output logic cpu_clk_en,
    output logic dma_en,
    output logic timer_p_units_en,
    output logic timer_q_unit_en,
    output logic i2c_units_en,
    output logic crc_en,
    output logic clocked_serial_units_en,
    output logic async_serial_units_en,
    output logic adc_en,
    output logic dac_en,
    output logic realtime_output_update_en,
    // units with conditional clocks
    output logic interval_timer_m_en,
    output logic wdt2_en,
    output logic watch_rtc_en,
    // interrupt and hold controls
    output logic intc_run_en,
    output logic intc_wake_en,
    output logic key_interrupt_unit_en,
    output logic port_hold,
    output logic cpu_reg_hold,
    output logic lv_subclk_mode
);
    // ==========================================================
    // state and registers
    lv_idle_pkg::state_type state_reg;
    logic [1:0] pms_reg;
    logic pll_run_reg;
    logic main_run_reg;
    logic lv_mode_reg;
    logic [1:0] tmm_sel_reg;
    logic [1:0] wdt_sel_reg;
    logic watch_sub_reg;
    logic adc_run_reg;
    logic dac_run_reg;
    logic refused_reg;
    logic woke_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic idle;
    logic do_write;
    logic ctrl_wr;
    logic clksel_wr;
    logic status_wr;
    logic stop_req;
    logic entry_ok;
    logic wake;
    assign idle = (state_reg == lv_idle_pkg::ST_IDLE);
    assign wake = idle && wake_req;
    // ==========================================================
    // axi4-lite write channel
    assign awready = !aw_got_reg && !bvalid;
    assign wready = !w_got_reg && !bvalid;
    assign do_write = aw_got_reg && w_got_reg && !bvalid;
    assign ctrl_wr = do_write && wstrb_reg[0] && (waddr_reg == lv_idle_pkg::CTRL_OFS);
    assign clksel_wr = do_write && wstrb_reg[0] && (waddr_reg == lv_idle_pkg::CLKSEL_OFS);
    assign status_wr = do_write && wstrb_reg[0] && (waddr_reg == lv_idle_pkg::STATUS_OFS);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= lv_idle_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got_reg <= 1'b1;
                waddr_reg <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid <= 1'b1;
                if (waddr_reg == lv_idle_pkg::CTRL_OFS || waddr_reg == lv_idle_pkg::CLKSEL_OFS ||
                    waddr_reg == lv_idle_pkg::STATUS_OFS) begin
                    bresp <= lv_idle_pkg::RESP_OKAY;
                end else begin
                    bresp <= lv_idle_pkg::RESP_SLVERR;
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi4-lite read channel
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= lv_idle_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= lv_idle_pkg::RESP_OKAY;
            rdata <= 32'h00000000;
            unique case ({araddr[7:2], 2'b00})
                lv_idle_pkg::CTRL_OFS: begin
                    rdata[7:0] <= {2'b00, lv_mode_reg, main_run_reg, pll_run_reg, 1'b0, pms_reg};
                end
                lv_idle_pkg::CLKSEL_OFS: begin
                    rdata[7:0] <= {1'b0, dac_run_reg, adc_run_reg, watch_sub_reg, wdt_sel_reg, tmm_sel_reg};
                end
                lv_idle_pkg::STATUS_OFS: begin
                    rdata[7:0] <= {5'h00, woke_reg, refused_reg, idle};
                end
                default: begin
                    rresp <= lv_idle_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // control register
    // mode select then stop bit
    assign stop_req = ctrl_wr && wdata_reg[lv_idle_pkg::STOP_BIT];
    // entry needs main clock and pll off
    assign entry_ok = stop_req && !idle && !wake_req &&
        (wdata_reg[lv_idle_pkg::PMS_LSB +: 2] == lv_idle_pkg::PMS_SUB_IDLE_A ||
         wdata_reg[lv_idle_pkg::PMS_LSB +: 2] == lv_idle_pkg::PMS_SUB_IDLE_B) &&
        !wdata_reg[lv_idle_pkg::MAIN_RUN_BIT] && !wdata_reg[lv_idle_pkg::PLL_RUN_BIT] &&
        wdata_reg[lv_idle_pkg::LV_MODE_BIT];
    // the core is halted in standby, so control writes are not expected there and are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pms_reg <= lv_idle_pkg::PMS_RESET;
            pll_run_reg <= lv_idle_pkg::PLL_RUN_RESET;
            main_run_reg <= lv_idle_pkg::MAIN_RUN_RESET;
            lv_mode_reg <= lv_idle_pkg::LV_MODE_RESET;
        end else if (ctrl_wr && !idle) begin
            pms_reg <= wdata_reg[lv_idle_pkg::PMS_LSB +: 2];
            pll_run_reg <= wdata_reg[lv_idle_pkg::PLL_RUN_BIT];
            main_run_reg <= wdata_reg[lv_idle_pkg::MAIN_RUN_BIT];
            lv_mode_reg <= wdata_reg[lv_idle_pkg::LV_MODE_BIT];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmm_sel_reg <= lv_idle_pkg::SEL_RESET;
            wdt_sel_reg <= lv_idle_pkg::SEL_RESET;
            watch_sub_reg <= 1'b0;
            adc_run_reg <= 1'b0;
            dac_run_reg <= 1'b0;
        end else if (clksel_wr && !idle) begin
            tmm_sel_reg <= wdata_reg[lv_idle_pkg::TMM_SEL_LSB +: 2];
            wdt_sel_reg <= wdata_reg[lv_idle_pkg::WDT_SEL_LSB +: 2];
            watch_sub_reg <= wdata_reg[lv_idle_pkg::WATCH_SUB_BIT];
            adc_run_reg <= wdata_reg[lv_idle_pkg::ADC_RUN_BIT];
            dac_run_reg <= wdata_reg[lv_idle_pkg::DAC_RUN_BIT];
        end
    end
    // ==========================================================
    // standby state machine
    // wake returns to low-voltage subclock mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= lv_idle_pkg::ST_ACTIVE;
        end else begin
            unique case (state_reg)
                lv_idle_pkg::ST_ACTIVE: begin
                    if (entry_ok) begin
                        state_reg <= lv_idle_pkg::ST_IDLE;
                    end
                end
                lv_idle_pkg::ST_IDLE: begin
                    if (wake_req) begin
                        state_reg <= lv_idle_pkg::ST_ACTIVE;
                    end
                end
                default: begin
                    state_reg <= lv_idle_pkg::ST_ACTIVE;
                end
            endcase
        end
    end
    // sticky flags: a new event wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_reg <= 1'b0;
            woke_reg <= 1'b0;
        end else begin
            if (stop_req && !entry_ok && !idle) begin
                refused_reg <= 1'b1;
            end else if (status_wr && wdata_reg[lv_idle_pkg::REFUSED_BIT]) begin
                refused_reg <= 1'b0;
            end
            if (wake) begin
                woke_reg <= 1'b1;
            end else if (status_wr && wdata_reg[lv_idle_pkg::WOKE_BIT]) begin
                woke_reg <= 1'b0;
            end
        end
    end
    // ==========================================================
    // gate decode
    // detector and oscillators stay on
    assign low_voltage_detector_en = 1'b1;
    assign subclk_osc_en = 1'b1;
    assign int_osc_en = 1'b1;
    // pll follows software only, never auto restart
    assign pll_en = pll_run_reg && !idle;
    assign main_clk_en = main_run_reg && !idle;
    assign cpu_clk_en = !idle;
    assign dma_en = !idle;
    assign timer_p_units_en = !idle;
    assign timer_q_unit_en = !idle;
    assign i2c_units_en = !idle;
    assign crc_en = !idle;
    assign clocked_serial_units_en = !idle;
    assign async_serial_units_en = !idle;
    assign adc_en = adc_run_reg && !idle;
    assign dac_en = dac_run_reg && !idle;
    assign realtime_output_update_en = !idle;
    // timer m and watchdog on slow clocks
    assign interval_timer_m_en = !idle || tmm_sel_reg == lv_idle_pkg::SEL_OSC_DIV8 ||
        tmm_sel_reg == lv_idle_pkg::SEL_SUBCLK;
    assign wdt2_en = !idle || wdt_sel_reg == lv_idle_pkg::SEL_OSC_DIV8 ||
        wdt_sel_reg == lv_idle_pkg::SEL_SUBCLK;
    assign watch_rtc_en = !idle || watch_sub_reg;
    assign intc_run_en = !idle;
    assign intc_wake_en = 1'b1;
    assign key_interrupt_unit_en = 1'b1;
    assign port_hold = idle;
    assign cpu_reg_hold = idle;
    assign lv_subclk_mode = lv_mode_reg;
    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_entry_main_off: assert property ($rose(idle) |-> !main_run_reg && !pll_run_reg)
        else $error("standby entered with main clock or pll running");
    a_intc_halt_wake: assert property (idle |-> !intc_run_en && intc_wake_en)
        else $error("interrupt controller not halted with wake path");
    a_tmm_gate_sel: assert property (idle && tmm_sel_reg == lv_idle_pkg::SEL_MAIN |-> !interval_timer_m_en)
        else $error("timer m runs on main clock in standby");
    a_watch_gate_sub: assert property (idle |-> watch_rtc_en == watch_sub_reg)
        else $error("watch timer gating wrong in standby");
    a_adc_dac_stop: assert property (idle |-> !adc_en && !dac_en)
        else $error("converter running in standby");
    a_rto_port_hold: assert property (idle |-> !realtime_output_update_en && port_hold && cpu_reg_hold)
        else $error("outputs not held in standby");
    a_key_alive: assert property (idle |-> key_interrupt_unit_en)
        else $error("key interrupt gated in standby");
    a_core_stop: assert property (idle |-> !cpu_clk_en && !dma_en && !crc_en && !i2c_units_en)
        else $error("core-side unit running in standby");
    a_wake_lv_mode: assert property (idle && wake_req |=> !idle && lv_subclk_mode && woke_reg)
        else $error("wake did not return to low-voltage subclock mode");
    a_pll_stays_off: assert property ($fell(idle) |-> !pll_en ##1 (!pll_en || $past(ctrl_wr)))
        else $error("pll restarted on release");
    a_refused_entry: assert property (stop_req && !idle && main_run_reg && !entry_ok |=> !idle && refused_reg)
        else $error("bad stop request not refused");
    c_enter_idle: cover property ($rose(idle));
    c_wake_release: cover property (idle && wake_req ##1 !idle);
    c_refused: cover property ($rose(refused_reg));
    c_timer_on_sub: cover property (idle && interval_timer_m_en);
endmodule
`default_nettype wire

//--- shared/lv_idle_pkg.sv
// Purpose: constants for the low-voltage sub-idle gating block
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: all control fields sit in byte lane 0
package lv_idle_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CLKSEL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // control register fields
    localparam int PMS_LSB = 0;
    localparam int STOP_BIT = 2;
    localparam int PLL_RUN_BIT = 3;
    localparam int MAIN_RUN_BIT = 4;
    localparam int LV_MODE_BIT = 5;
    // clock select register fields
    localparam int TMM_SEL_LSB = 0;
    localparam int WDT_SEL_LSB = 2;
    localparam int WATCH_SUB_BIT = 4;
    localparam int ADC_RUN_BIT = 5;
    localparam int DAC_RUN_BIT = 6;
    // status register fields
    localparam int IDLE_BIT = 0;
    localparam int REFUSED_BIT = 1;
    localparam int WOKE_BIT = 2;
    // power mode select codes that request sub-idle
    localparam logic [1:0] PMS_SUB_IDLE_A = 2'h0;
    localparam logic [1:0] PMS_SUB_IDLE_B = 2'h2;
    // count clock select codes
    localparam logic [1:0] SEL_MAIN = 2'h0;
    localparam logic [1:0] SEL_OSC_DIV8 = 2'h1;
    localparam logic [1:0] SEL_SUBCLK = 2'h2;
    // reset values
    localparam logic [1:0] PMS_RESET = 2'h0;
    localparam logic PLL_RUN_RESET = 1'b0;
    localparam logic MAIN_RUN_RESET = 1'b1;
    localparam logic LV_MODE_RESET = 1'b0;
    localparam logic [1:0] SEL_RESET = 2'h0;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b01,
        ST_IDLE = 2'b10
    } state_type;
endpackage
